// File: eeprom_rd_params.svh
// Constants for the two-wire EEPROM read path
`ifndef EEPROM_RD_PARAMS_SVH
`define EEPROM_RD_PARAMS_SVH
`define DEV_TYPE_CODE   4'b1010
`define ADDR_WIDTH      13
`define ADDR_TOP        13'h1FFF
`define ADDR_RESET      13'h0000
`define BIT_CNT_LAST    4'h8
`define SYNC_STAGES     3
`endif

// File: eeprom_rd_pkg.sv
// Types shared by the EEPROM read path
package eeprom_rd_pkg;
  // Protocol phase of the slave
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,  // Waiting for START
    ST_DEVADR = 3'b001,  // Shifting in slave address
    ST_WRADR  = 3'b010,  // Shifting in location address bytes
    ST_WRDATA = 3'b011,  // Write data ignored on read path
    ST_TXDATA = 3'b100,  // Shifting out a data byte
    ST_MACK   = 3'b101,  // Master acknowledge slot
    ST_WAIT   = 3'b110   // Waiting for STOP
  } phase_t;
  // Synchronised bus levels and events
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } bus_evt_t;
  // Memory read request (address only)
  typedef struct packed {
    logic [12:0] addr;
  } mem_req_t;
endpackage

// File: pin_sync.sv
// Three-stage input synchroniser with edge and bus-condition detection
`timescale 1ns/1ps
`include "eeprom_rd_params.svh"
module pin_sync
  import eeprom_rd_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output eeprom_rd_pkg::bus_evt_t evt
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [2:0] scl_sync_reg;  // Stage 0 read only by stage 1
  logic [2:0] sda_sync_reg;
  logic       scl_reg;       // Filtered level
  logic       sda_reg;

  // Shift chains; bus idles high
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scl_sync_reg <= 3'b111;
      sda_sync_reg <= 3'b111;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
    end
  end

  // A change counts only when stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_reg <= sda_sync_reg[2];
      end
    end
  end

  // Events derived from agreed levels only
  always_comb begin
    evt.scl      = scl_reg;
    evt.sda      = sda_reg;
    evt.scl_rise = (scl_sync_reg[1] == scl_sync_reg[2]) && scl_sync_reg[2] && !scl_reg;
    evt.scl_fall = (scl_sync_reg[1] == scl_sync_reg[2]) && !scl_sync_reg[2] && scl_reg;
    // Data moving while clock high marks START or STOP
    evt.start    = scl_reg && (sda_sync_reg[1] == sda_sync_reg[2]) &&
                   !sda_sync_reg[2] && sda_reg;
    evt.stop     = scl_reg && (sda_sync_reg[1] == sda_sync_reg[2]) &&
                   sda_sync_reg[2] && !sda_reg;
  end
endmodule

// File: i2c_eeprom_read_path.sv
// Read side of a two-wire serial EEPROM slave
//
// Overview of operation
// - Direction bit one selects a read.
// - Counter holds last location plus one.
// - Counter wraps from 8191 to 0.
// - Acknowledge address, then shift out byte.
// - Repeated START read returns loaded location.
// - Master ack on first byte starts sequential.
// - Each master ack sends next byte.
// - No-ack then STOP ends; release data.
// - Increment full counter width on reads.
// - Match 1010 plus three select pins.
// - No-ack: release line, wait for STOP.
`timescale 1ns/1ps
`include "eeprom_rd_params.svh"
module i2c_eeprom_read_path
  import eeprom_rd_pkg::*;
#(
  parameter int ADDR_W = `ADDR_WIDTH  // Location address width
)(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_oe_n,          // Low while pulling data low
  output logic                   sda_out,           // Always zero when driven
  input  wire logic              chip_select_bit0,
  input  wire logic              chip_select_bit1,
  input  wire logic              chip_select_bit2,
  output eeprom_rd_pkg::mem_req_t mem_req,          // Array read address
  input  wire logic [7:0]        mem_rdata,         // Array data, same-cycle
  output logic                   busy               // Inside a transaction
);
  import eeprom_rd_pkg::*;

  // Elaboration check on address width
  if (ADDR_W != 13) begin : g_bad_width
    $error("Address width must be 13");
  end

  ////////////////////////////////////////////////////////////////////////////////
  bus_evt_t          evt;             // Synchronised bus events
  phase_t            state_reg;       // Protocol phase
  logic [3:0]        bit_cnt_reg;     // Bits of current byte seen
  logic [7:0]        shift_reg;       // Receive or transmit byte
  logic [12:0]       addr_cnt_reg;    // Address counter
  logic              addr_hi_reg;     // High address byte pending
  logic              ack_slot_reg;    // Device is in its own ack slot
  logic              rw_reg;          // Direction bit of matched address
  logic              master_ack_reg;  // Sampled master acknowledge
  logic [2:0]        sel_pins;

  assign sel_pins = {chip_select_bit2, chip_select_bit1, chip_select_bit0};

  // Increment wraps over the whole counter, not just page bits
  function automatic logic [12:0] next_addr(input logic [12:0] a);
    next_addr = (a == `ADDR_TOP) ? `ADDR_RESET : 13'(a + 13'h0001);
  endfunction
  // Slave address byte matches type code and select pins
  function automatic logic addr_match(input logic [7:0] b, input logic [2:0] pins);
    addr_match = (b[7:4] == `DEV_TYPE_CODE) && (b[3:1] == pins);
  endfunction

  pin_sync u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .evt     (evt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Protocol phase machine; START and STOP override everything
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg      <= ST_IDLE;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      addr_hi_reg    <= 1'b0;
      ack_slot_reg   <= 1'b0;
      rw_reg         <= 1'b0;
      master_ack_reg <= 1'b0;
    end else if (evt.start) begin
      // Repeated START is legal anywhere
      state_reg    <= ST_DEVADR;
      bit_cnt_reg  <= 4'h0;
      ack_slot_reg <= 1'b0;
    end else if (evt.stop) begin
      state_reg    <= ST_IDLE;
      ack_slot_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE, ST_WAIT: begin
          bit_cnt_reg <= 4'h0;
        end
        ST_DEVADR, ST_WRADR, ST_WRDATA: begin
          // Receive on rising clock
          if (evt.scl_rise && !ack_slot_reg) begin
            shift_reg   <= {shift_reg[6:0], evt.sda};
            bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
          end
          if (evt.scl_fall && ack_slot_reg) begin
            // End of device ack slot
            ack_slot_reg <= 1'b0;
            bit_cnt_reg  <= 4'h0;
            if (state_reg == ST_DEVADR && rw_reg) begin
              state_reg <= ST_TXDATA;
              shift_reg <= mem_rdata;
            end else if (state_reg == ST_DEVADR) begin
              state_reg   <= ST_WRADR;
              addr_hi_reg <= 1'b1;
            end else if (state_reg == ST_WRADR && addr_hi_reg) begin
              addr_hi_reg <= 1'b0;  // Low address byte follows
            end else if (state_reg == ST_WRADR) begin
              state_reg <= ST_WRDATA;
            end
          end else if (evt.scl_fall && bit_cnt_reg == `BIT_CNT_LAST) begin
            if (state_reg == ST_DEVADR) begin
              if (addr_match(shift_reg, sel_pins)) begin
                rw_reg       <= shift_reg[0];
                ack_slot_reg <= 1'b1;
              end else begin
                state_reg <= ST_WAIT;
              end
            end else if (state_reg == ST_WRADR) begin
              ack_slot_reg <= 1'b1;
            end else begin
              // Write data belongs to the write path; do not ack
              state_reg <= ST_WAIT;
            end
          end
        end
        ST_TXDATA: begin
          // shift byte out after clock falls
          if (evt.scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              state_reg   <= ST_MACK;
              bit_cnt_reg <= 4'h0;
            end else begin
              shift_reg   <= {shift_reg[6:0], 1'b0};
              bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
            end
          end
        end
        ST_MACK: begin
          // sample master ack while clock high
          if (evt.scl_rise) begin
            master_ack_reg <= !evt.sda;
          end
          if (evt.scl_fall) begin
            if (master_ack_reg) begin
              state_reg <= ST_TXDATA;
              shift_reg <= mem_rdata;
            end else begin
              // no ack, release and wait for STOP
              state_reg <= ST_WAIT;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address counter; survives STOP so current-address reads work
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      addr_cnt_reg <= `ADDR_RESET;
    end else if (!evt.start && !evt.stop && evt.scl_fall) begin
      if (state_reg == ST_WRADR && bit_cnt_reg == `BIT_CNT_LAST && !ack_slot_reg) begin
        if (addr_hi_reg) begin
          addr_cnt_reg <= {shift_reg[4:0], addr_cnt_reg[7:0]};
        end else begin
          addr_cnt_reg <= {addr_cnt_reg[12:8], shift_reg};
        end
      end else if (state_reg == ST_TXDATA && bit_cnt_reg == 4'h7) begin
        // counter steps past the byte just sent
        addr_cnt_reg <= next_addr(addr_cnt_reg);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Open-drain data driver; output enable is low while pulling low
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sda_oe_n <= 1'b1;
    end else if (evt.start || evt.stop) begin
      sda_oe_n <= 1'b1;
    end else if (ack_slot_reg && evt.scl_fall) begin
      // Leaving ack slot: first data bit may follow at once
      sda_oe_n <= !(state_reg == ST_DEVADR && rw_reg && !mem_rdata[7]);
    end else if (evt.scl_fall && bit_cnt_reg == `BIT_CNT_LAST && (state_reg == ST_WRADR ||
                 (state_reg == ST_DEVADR && addr_match(shift_reg, sel_pins)))) begin
      // Pull low on the fall that ends the byte, so the ack settles before clock rises
      sda_oe_n <= 1'b0;
    end else if (ack_slot_reg) begin
      sda_oe_n <= 1'b0;
    end else if (state_reg == ST_TXDATA && evt.scl_fall) begin
      sda_oe_n <= (bit_cnt_reg == 4'h7) ? 1'b1 : shift_reg[6];
    end else if (state_reg == ST_MACK && evt.scl_fall) begin
      sda_oe_n <= !(master_ack_reg && !mem_rdata[7]);
    end else if (state_reg != ST_TXDATA) begin
      sda_oe_n <= 1'b1;
    end
  end

  // Data level is always low; the enable alone decides
  always_ff @(posedge sys_clk) begin
    sda_out <= 1'b0;
  end

  // Array address and busy flag
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mem_req.addr <= `ADDR_RESET;
      busy         <= 1'b0;
    end else begin
      mem_req.addr <= addr_cnt_reg;
      busy         <= (state_reg != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Released during master ack slot
  master_release_a:
  assert property (@(posedge sys_clk) disable iff (reset)
    (state_reg == ST_MACK && !evt.scl_fall) |=> sda_oe_n)
    else $error("Data line driven during master ack slot");

  // Wrap at top
  counter_wrap_a:
  assert property (@(posedge sys_clk) disable iff (reset)
    (addr_cnt_reg == `ADDR_TOP && state_reg == ST_TXDATA && bit_cnt_reg == 4'h7
     && evt.scl_fall && !evt.start && !evt.stop) |=> addr_cnt_reg == `ADDR_RESET)
    else $error("Counter did not wrap to zero");

  // Full-width increment
  counter_step_a:
  assert property (@(posedge sys_clk) disable iff (reset)
    (state_reg == ST_TXDATA && bit_cnt_reg == 4'h7 && evt.scl_fall && !evt.start
     && !evt.stop && addr_cnt_reg != `ADDR_TOP)
    |=> addr_cnt_reg == $past(addr_cnt_reg) + 13'h0001)
    else $error("Counter did not step by one");

  // No ack leads to wait
  noack_wait_a:
  assert property (@(posedge sys_clk) disable iff (reset)
    (state_reg == ST_MACK && evt.scl_fall && !master_ack_reg && !evt.start && !evt.stop)
    |=> state_reg == ST_WAIT ##1 sda_oe_n)
    else $error("No-ack did not end transmission");

  // Ack leads to next byte
  ack_next_a:
  assert property (@(posedge sys_clk) disable iff (reset)
    (state_reg == ST_MACK && evt.scl_fall && master_ack_reg && !evt.start && !evt.stop)
    |=> state_reg == ST_TXDATA && bit_cnt_reg == 4'h0)
    else $error("Master ack did not start next byte");

  // Wrong device type code never acknowledged
  addr_match_a:
  assert property (@(posedge sys_clk) disable iff (reset)
    (state_reg == ST_DEVADR && bit_cnt_reg == `BIT_CNT_LAST && evt.scl_fall
     && !ack_slot_reg && !evt.start && !evt.stop && shift_reg[7:4] != `DEV_TYPE_CODE)
    |=> state_reg == ST_WAIT && !ack_slot_reg)
    else $error("Foreign address acknowledged");

  // STOP releases line
  stop_release_a:
  assert property (@(posedge sys_clk) disable iff (reset)
    evt.stop |=> sda_oe_n && state_reg == ST_IDLE)
    else $error("STOP did not release data line");

  // Read address goes to transmit
  read_select_a:
  assert property (@(posedge sys_clk) disable iff (reset)
    (state_reg == ST_DEVADR && ack_slot_reg && rw_reg && evt.scl_fall
     && !evt.start && !evt.stop) |=> state_reg == ST_TXDATA)
    else $error("Read direction did not start transmission");
endmodule

// File: i2c_master_model.sv
// Bus master model that clocks and addresses the EEPROM read path
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic sys_clk,
  input  wire logic sda_bus,
  output logic      scl,
  output logic      sda_drv
);
  int slow;  // Extra low-phase cycles, lets the master run slowly

  // Bus idle: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    slow = 0;
  end

  // Wait a number of system clocks
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // One bus clock; data set early in low phase, bus sampled late in high
  // phase so the slave's own synchroniser delay is absorbed
  task automatic pulse(input logic d, output logic s);
    tick(1);
    sda_drv <= d;
    // Low phase outlasts the slave's synchroniser plus its output flop
    tick(4 + slow);
    scl <= 1'b1;
    tick(2);
    s = sda_bus;
    tick(1);
    scl <= 1'b0;
  endtask

  task automatic bus_start();
    tick(1);
    sda_drv <= 1'b1;
    tick(6);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask

  task automatic bus_stop();
    tick(1);
    sda_drv <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(4);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(b[i], s);
    pulse(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv_byte(input logic give_ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b1, s);
      b[i] = s;
    end
    pulse(~give_ack, s);
  endtask
endmodule

// File: test_i2c_eeprom_read_path.sv
// Self-checking bench for the EEPROM read path
`timescale 1ns/1ps
module test_i2c_eeprom_read_path;
  import eeprom_rd_pkg::*;
  logic       sys_clk;
  logic       reset;
  logic       scl;
  logic       sda_drv;
  wire        sda_bus;
  logic       sda_oe_n;
  logic       sda_out;
  logic [2:0] sel;         // Select pin levels
  mem_req_t   mem_req;
  logic [7:0] mem_rdata;
  logic       busy;
  int         fail_count;
  int         num_checks;
  int         cycles;      // Hang guard

  // Open-drain wire with pull-up: low while either party pulls
  assign sda_bus = sda_drv & (sda_oe_n | sda_out);

  // Array model: pattern differs between neighbours and across wrap
  function automatic logic [7:0] pat(input logic [12:0] a);
    return a[7:0] ^ {a[12:8], 3'b101};
  endfunction
  assign mem_rdata = pat(mem_req.addr);

  i2c_eeprom_read_path DUT (
    .sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda_bus),
    .sda_oe_n(sda_oe_n), .sda_out(sda_out), .chip_select_bit0(sel[0]),
    .chip_select_bit1(sel[1]), .chip_select_bit2(sel[2]),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .busy(busy));

  i2c_master_model master (
    .sys_clk(sys_clk), .sda_bus(sda_bus), .scl(scl), .sda_drv(sda_drv));

  // 50 ns system clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare with case equality so an unknown never matches
  task automatic check(input string what, input logic [12:0] exp,
                       input logic [12:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Single place where the run ends
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Whole run needs well under this many cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Send one byte and compare the acknowledge
  task automatic send_chk(input string what, input logic [7:0] b, input logic exp);
    logic ack;
    master.send_byte(b, ack);
    check(what, exp, ack);
  endtask

  task automatic load(input logic [12:0] a);
    master.bus_start();
    send_chk("write select ack", {4'b1010, sel, 1'b0}, 1'b1);
    send_chk("addr high ack", {3'b000, a[12:8]}, 1'b1);
    send_chk("addr low ack", a[7:0], 1'b1);
  endtask

  // Read n bytes from a, no-ack on the last one, then STOP
  task automatic read_run(input logic [12:0] a, input int n);
    logic [7:0] d;
    master.bus_start();
    send_chk("read select ack", {4'b1010, sel, 1'b1}, 1'b1);
    for (int k = 0; k < n; k++) begin
      master.recv_byte(k < n - 1, d);
      check("read data", pat(a + 13'(k)), d);
    end
    master.tick(6);
    check("released before stop", 1'b1, sda_oe_n);
    check("busy before stop", 1'b1, busy);
    master.bus_stop();
    master.tick(6);
    check("data line released", 1'b1, sda_oe_n);
    check("idle after stop", 1'b0, busy);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reset values, then a current-address read from counter zero
  task automatic t_reset();
    check("reset release", 1'b1, sda_oe_n);
    check("reset drive value", 1'b0, sda_out);
    check("reset busy", 1'b0, busy);
    check("reset address", 13'h0000, mem_req.addr);
    read_run(13'h0000, 1);
    $display("test reset done");
  endtask

  // Random read at the top, sequential through the wrap, then current read
  task automatic t_wrap();
    load(13'h1FFE);
    read_run(13'h1FFE, 3);
    read_run(13'h0001, 2);
    $display("test wrap done");
  endtask

  // Slow master crossing the low-byte boundary
  task automatic t_cross();
    master.slow = 3;
    load(13'h00FE);
    read_run(13'h00FE, 4);
    master.slow = 0;
    $display("test cross done");
  endtask

  // Every select pin combination answers its own address
  task automatic t_select();
    for (int s = 0; s < 8; s++) begin
      @(posedge sys_clk);
      sel <= 3'(s);
      master.tick(2);
      load(13'h0A40 + 13'(s));
      read_run(13'h0A40 + 13'(s), 1);
    end
    $display("test select done");
  endtask

  // Foreign addresses and a write data byte are not acknowledged
  task automatic t_refuse();
    master.bus_start();
    send_chk("wrong type", {4'b1011, sel, 1'b1}, 1'b0);
    master.bus_stop();
    master.bus_start();
    send_chk("wrong select", {4'b1010, ~sel, 1'b1}, 1'b0);
    master.bus_stop();
    load(13'h0005);
    send_chk("write data", 8'h3C, 1'b0);
    master.bus_stop();
    master.tick(6);
    check("idle after refusal", 1'b0, busy);
    check("line after refusal", 1'b1, sda_oe_n);
    $display("test refuse done");
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    sel = 3'b000;
    cycles = 0;
    fail_count = 0;
    num_checks = 0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    master.tick(6);
    t_reset();
    t_wrap();
    t_cross();
    t_refuse();
    t_select();
    wrap_up();
  end
endmodule
